//--- pxee_core.sv
// Exception entry, return and reset sequencing of the processor core
`timescale 1ns/10ps
module pxee_core (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Reset pins and configuration straps
    input wire logic i_core_reset_low,
    input wire logic i_halt_hold_low,
    input wire logic i_init_big_endian_cfg,
    input wire logic i_init_compact_state_cfg,
    input wire logic i_unmaskable_fast_cfg,
    // Interrupt pins
    input wire logic i_normal_irq_low,
    input wire logic i_fast_irq_low,
    // System control word bits
    input wire logic i_exception_endian_bit,
    input wire logic i_exception_state_bit,
    // Synchronous exception request from the pipeline
    input wire logic i_exc_req,
    input wire logic [2:0] i_exc_class,
    input wire logic [31:0] i_instr_addr,
    // Return with flag-setting option
    input wire logic i_return_req,
    input wire logic i_return_flag_set,
    // Software write of the status word
    input wire logic i_status_wr,
    input wire logic [31:0] i_status_wdata,
    // Fast mode private registers
    input wire logic i_bank_wr,
    input wire logic [2:0] i_bank_widx,
    input wire logic [31:0] i_bank_wdata,
    input wire logic [2:0] i_bank_ridx,
    // Status and sequencing outputs
    output logic [31:0] o_current_status_word,
    output logic [31:0] o_saved_status_word,
    output logic [31:0] o_return_link_reg,
    output logic [31:0] o_bank_rdata,
    output logic o_fetch_redirect,
    output logic [2:0] o_fetch_vector,
    output logic o_ready,
    output logic o_in_reset
);
    import pxee_pkg::*;

    pxee_regs_t r;
    pxee_regs_t next_r;

    // ****************************************
    // Conditional block advance
    // ****************************************
    function automatic logic [31:0] advance_cond(input logic [31:0] sw);
        logic [7:0] it;
        logic [31:0] res;
        it = {sw[SW_ITH_LSB+5:SW_ITH_LSB], sw[SW_ITL_LSB+1:SW_ITL_LSB]};
        if (it[2:0] == 3'h0) begin
            it = 8'h00;
        end else begin
            it[4:0] = {it[3:0], 1'b0};
        end
        res = sw;
        res[SW_ITH_LSB+5:SW_ITH_LSB] = it[7:2];
        res[SW_ITL_LSB+1:SW_ITL_LSB] = it[1:0];
        return res;
    endfunction

    // ****************************************
    // Link offset by class and prior state
    // ****************************************
    function automatic logic [31:0] link_offset(input logic [2:0] cls, input logic compact);
        case (cls)
            CLS_SVC, CLS_UNDEF: link_offset = compact ? LINK_OFS_COMPACT : LINK_OFS_WIDE;
            CLS_DATA_ABORT: link_offset = LINK_OFS_DATA;
            default: link_offset = LINK_OFS_WIDE;
        endcase
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    logic fast_pend;
    logic normal_pend;
    logic take;
    logic [2:0] cls;
    logic [4:0] tmode;
    logic [2:0] tbank;
    logic [2:0] cbank;
    logic priv;
    logic [31:0] wmask;
    logic [31:0] sw;

    always_comb begin
        next_r = r;
        next_r.redirect = 1'b0;
        fast_pend = 1'b0;
        normal_pend = 1'b0;
        take = 1'b0;
        cls = CLS_SVC;
        tmode = MODE_SUPER;
        tbank = BANK_SUPER;
        cbank = pxee_bank(r.status[4:0]);
        priv = (r.status[4:0] != MODE_USER);
        wmask = SW_USER_WR_MASK;
        sw = r.status;

        case (r.state)
            ST_RESET: begin
                // Leave reset only when both pins are high
                if (i_core_reset_low && i_halt_hold_low) begin
                    sw = SW_RESET;
                    sw[4:0] = MODE_SUPER;
                    sw[SW_A_BIT] = 1'b1;
                    sw[SW_I_BIT] = 1'b1;
                    sw[SW_F_BIT] = 1'b1;
                    sw[SW_E_BIT] = i_init_big_endian_cfg;
                    sw[SW_T_BIT] = i_init_compact_state_cfg;
                    next_r.status = sw;
                    next_r.vector = CLS_RESET;
                    next_r.state = ST_VECTOR;
                    next_r.in_reset = 1'b0;
                end
            end
            ST_RUN: begin
                // Software write of the status word
                if (i_status_wr) begin
                    if (priv) begin
                        wmask = SW_USER_WR_MASK | SW_PRIV_WR_MASK;
                    end
                    sw = (r.status & ~wmask) | (i_status_wdata & wmask);
                    if (priv && i_unmaskable_fast_cfg) begin
                        sw[SW_F_BIT] = r.status[SW_F_BIT] & i_status_wdata[SW_F_BIT];
                    end
                    if (priv && (pxee_bank(sw[4:0]) == BANK_NONE) && (sw[4:0] != MODE_USER)) begin
                        sw[4:0] = MODE_SYSTEM;
                    end
                end
                // Return restores the saved word of the current mode
                if (i_return_req && i_return_flag_set && (cbank != BANK_NONE)) begin
                    sw = r.saved[cbank];
                end
                next_r.status = sw;

                // Masking and priority of interrupts
                fast_pend = !i_fast_irq_low && !r.status[SW_F_BIT];
                normal_pend = !i_normal_irq_low && !r.status[SW_I_BIT];
                if (i_exc_req && (i_exc_class == CLS_DATA_ABORT)) begin
                    take = 1'b1;
                    cls = CLS_DATA_ABORT;
                end else if (fast_pend) begin
                    take = 1'b1;
                    cls = CLS_FAST_IRQ;
                end else if (normal_pend) begin
                    take = 1'b1;
                    cls = CLS_NORMAL_IRQ;
                end else if (i_exc_req && (i_exc_class <= CLS_BREAKPOINT)) begin
                    take = 1'b1;
                    cls = i_exc_class;
                end

                if (take) begin
                    tmode = pxee_target_mode(cls);
                    tbank = pxee_bank(tmode);
                    // Offset from the state before entry overwrites it
                    next_r.link[tbank] = i_instr_addr + link_offset(cls, r.status[SW_T_BIT]);
                    if (cls == CLS_SVC) begin
                        next_r.saved[tbank] = advance_cond(r.status);
                    end else begin
                        next_r.saved[tbank] = r.status;
                    end
                    sw = r.status & ~SW_IT_MASK;
                    sw[4:0] = tmode;
                    sw[SW_E_BIT] = i_exception_endian_bit;
                    sw[SW_T_BIT] = i_exception_state_bit;
                    sw[SW_I_BIT] = 1'b1;
                    if (cls == CLS_FAST_IRQ) begin
                        sw[SW_F_BIT] = 1'b1;
                    end
                    if ((cls == CLS_FAST_IRQ) || (cls == CLS_NORMAL_IRQ) || (tmode == MODE_ABORT)) begin
                        sw[SW_A_BIT] = 1'b1;
                    end
                    next_r.status = sw;
                    next_r.vector = cls;
                    next_r.state = ST_VECTOR;
                end
            end
            ST_VECTOR: begin
                next_r.redirect = 1'b1;
                next_r.state = ST_RUN;
            end
            default: begin
                next_r.state = ST_RESET;
            end
        endcase

        // Fast private registers, writable only in fast mode
        if (i_bank_wr && (r.status[4:0] == MODE_FAST) && (r.state == ST_RUN)) begin
            next_r.fast_bank[i_bank_widx] = i_bank_wdata;
        end

        // Reset pin low abandons the state and the redirect; status, saved, link and bank writes of this cycle still land
        if (!i_core_reset_low) begin
            next_r.state = ST_RESET;
            next_r.redirect = 1'b0;
            next_r.in_reset = 1'b1;
        end

        // Registered views of the current mode's bank and of the fast private register at i_bank_ridx
        cbank = pxee_bank(next_r.status[4:0]);
        if (cbank != BANK_NONE) begin
            next_r.out_saved = next_r.saved[cbank];
            next_r.out_link = next_r.link[cbank];
        end else begin
            next_r.out_saved = WORD_RESET;
            next_r.out_link = WORD_RESET;
        end
        next_r.out_bank = next_r.fast_bank[i_bank_ridx];
        next_r.ready = (next_r.state == ST_RUN);
    end

    // ****************************************
    // State register
    // ****************************************
    // Banked links clear to zero on reset, with all registers but vector and in_reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
            r.state <= ST_RESET;
            r.status <= SW_RESET;
            r.vector <= CLS_RESET;
            r.in_reset <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_current_status_word = r.status;
    assign o_saved_status_word = r.out_saved;
    assign o_return_link_reg = r.out_link;
    assign o_bank_rdata = r.out_bank;
    assign o_fetch_redirect = r.redirect;
    assign o_fetch_vector = r.vector;
    assign o_ready = r.ready;
    assign o_in_reset = r.in_reset;

endmodule

//--- pxee_irq_src.sv
// Model of the interrupt sources behind the two request pins
`timescale 1ns/10ps
module pxee_irq_src (
    // Clock, reset and commands, bit 1 fast, bit 0 normal
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_fire,
    input wire logic [1:0] i_ack,
    // Request pins
    output logic [1:0] o_irq_low
);
    // Request held low until the handler acknowledges
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq_low <= 2'h3;
        end else begin
            o_irq_low <= (o_irq_low | i_ack) & ~i_fire;
        end
    end
endmodule

//--- pxee_pkg.sv
// Constants, types and helper functions of the exception sequencer
package pxee_pkg;

    // ****************************************
    // Mode encodings
    // ****************************************
    localparam logic [4:0] MODE_USER = 5'h10;
    localparam logic [4:0] MODE_FAST = 5'h11;
    localparam logic [4:0] MODE_NORMAL = 5'h12;
    localparam logic [4:0] MODE_SUPER = 5'h13;
    localparam logic [4:0] MODE_ABORT = 5'h17;
    localparam logic [4:0] MODE_UNDEF = 5'h1B;
    localparam logic [4:0] MODE_SYSTEM = 5'h1F;

    // ****************************************
    // Status word layout
    // ****************************************
    localparam int SW_T_BIT = 5;
    localparam int SW_F_BIT = 6;
    localparam int SW_I_BIT = 7;
    localparam int SW_A_BIT = 8;
    localparam int SW_E_BIT = 9;
    localparam int SW_ITL_LSB = 25;
    localparam int SW_ITH_LSB = 10;
    localparam logic [31:0] SW_IT_MASK = 32'h0600FC00;
    localparam logic [31:0] SW_USER_WR_MASK = 32'hF80F0200;
    localparam logic [31:0] SW_PRIV_WR_MASK = 32'h000001DF;
    localparam logic [31:0] SW_RESET = 32'h00000000;
    localparam logic [31:0] WORD_RESET = 32'h00000000;

    // ****************************************
    // Exception classes, also the vector selector
    // ****************************************
    localparam logic [2:0] CLS_SVC = 3'h0;
    localparam logic [2:0] CLS_UNDEF = 3'h1;
    localparam logic [2:0] CLS_FETCH_ABORT = 3'h2;
    localparam logic [2:0] CLS_DATA_ABORT = 3'h3;
    localparam logic [2:0] CLS_BREAKPOINT = 3'h4;
    localparam logic [2:0] CLS_FAST_IRQ = 3'h5;
    localparam logic [2:0] CLS_NORMAL_IRQ = 3'h6;
    localparam logic [2:0] CLS_RESET = 3'h7;

    // ****************************************
    // Link offsets and banks
    // ****************************************
    localparam logic [31:0] LINK_OFS_WIDE = 32'h00000004;
    localparam logic [31:0] LINK_OFS_COMPACT = 32'h00000002;
    localparam logic [31:0] LINK_OFS_DATA = 32'h00000008;
    localparam int FAST_BANK_REGS = 8;
    localparam int MODE_BANKS = 5;
    localparam logic [2:0] BANK_FAST = 3'h0;
    localparam logic [2:0] BANK_NORMAL = 3'h1;
    localparam logic [2:0] BANK_SUPER = 3'h2;
    localparam logic [2:0] BANK_ABORT = 3'h3;
    localparam logic [2:0] BANK_UNDEF = 3'h4;
    localparam logic [2:0] BANK_NONE = 3'h7;

    typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_VECTOR} pxee_state_t;

    typedef struct packed {
        pxee_state_t state;
        logic [31:0] status;
        logic [MODE_BANKS-1:0][31:0] saved;
        logic [MODE_BANKS-1:0][31:0] link;
        logic [FAST_BANK_REGS-1:0][31:0] fast_bank;
        logic [31:0] out_saved;
        logic [31:0] out_link;
        logic [31:0] out_bank;
        logic redirect;
        logic [2:0] vector;
        logic ready;
        logic in_reset;
    } pxee_regs_t;

    // Mode of each exception class
    function automatic logic [4:0] pxee_target_mode(input logic [2:0] cls);
        case (cls)
            CLS_SVC, CLS_RESET: pxee_target_mode = MODE_SUPER;
            CLS_UNDEF: pxee_target_mode = MODE_UNDEF;
            CLS_FAST_IRQ: pxee_target_mode = MODE_FAST;
            CLS_NORMAL_IRQ: pxee_target_mode = MODE_NORMAL;
            default: pxee_target_mode = MODE_ABORT;
        endcase
    endfunction

    // Bank index of a mode, BANK_NONE for user and system
    function automatic logic [2:0] pxee_bank(input logic [4:0] mode);
        case (mode)
            MODE_FAST: pxee_bank = BANK_FAST;
            MODE_NORMAL: pxee_bank = BANK_NORMAL;
            MODE_SUPER: pxee_bank = BANK_SUPER;
            MODE_ABORT: pxee_bank = BANK_ABORT;
            MODE_UNDEF: pxee_bank = BANK_UNDEF;
            default: pxee_bank = BANK_NONE;
        endcase
    endfunction

endpackage

//--- pxee_props.sv
// Port assertions of the exception sequencer
`timescale 1ns/10ps
module pxee_props (
    // Clock, reset and pins
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_core_reset_low,
    input wire logic i_halt_hold_low,
    input wire logic i_init_big_endian_cfg,
    input wire logic i_init_compact_state_cfg,
    input wire logic i_normal_irq_low,
    input wire logic i_fast_irq_low,
    // Requests
    input wire logic i_exception_endian_bit,
    input wire logic i_exception_state_bit,
    input wire logic i_exc_req,
    input wire logic [2:0] i_exc_class,
    input wire logic [31:0] i_instr_addr,
    input wire logic i_return_req,
    input wire logic i_return_flag_set,
    input wire logic i_status_wr,
    // Outputs
    input wire logic [31:0] o_current_status_word,
    input wire logic [31:0] o_saved_status_word,
    input wire logic [31:0] o_return_link_reg,
    input wire logic o_fetch_redirect,
    input wire logic [2:0] o_fetch_vector,
    input wire logic o_ready,
    input wire logic o_in_reset
);
    import pxee_pkg::*;
    logic [31:0] sw;
    logic run, da, tf, tn, ts, tk, t_now;
    assign sw = o_current_status_word;
    assign t_now = sw[SW_T_BIT];
    assign run = o_ready && i_core_reset_low;
    assign da = i_exc_req && i_exc_class == CLS_DATA_ABORT;
    // Take decisions in priority order
    assign tf = run && !i_fast_irq_low && !sw[SW_F_BIT] && !da;
    assign tn = run && !i_normal_irq_low && !sw[SW_I_BIT] && !da && !tf;
    assign ts = run && i_exc_req && i_exc_class <= CLS_BREAKPOINT && !tf && !tn;
    assign tk = tf || tn || ts;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_gap;
        !o_ready && !o_fetch_redirect;
    endsequence
    sequence s_vec;
        o_fetch_redirect && o_ready;
    endsequence
    chk_take_vector: assert property (tk |=> s_gap ##1 s_vec)
        else $error("no vector fetch after entry");
    chk_link_data: assert property (run && da |=> o_return_link_reg == $past(i_instr_addr) + LINK_OFS_DATA)
        else $error("data abort link wrong");
    chk_link_call: assert property (ts && i_exc_class == CLS_SVC |=> o_return_link_reg == $past(i_instr_addr) +
        ($past(t_now) ? LINK_OFS_COMPACT : LINK_OFS_WIDE)) else $error("call link wrong");
    chk_fast_entry: assert property (tf |=> sw[4:0] == MODE_FAST && sw[SW_F_BIT] && sw[SW_I_BIT] &&
        o_return_link_reg == $past(i_instr_addr) + LINK_OFS_WIDE) else $error("fast entry wrong");
    chk_normal_entry: assert property (tn |=> sw[4:0] == MODE_NORMAL && sw[SW_I_BIT])
        else $error("normal entry wrong");
    chk_entry_bits: assert property (tk |=> sw[SW_E_BIT] == $past(i_exception_endian_bit) &&
        sw[SW_T_BIT] == $past(i_exception_state_bit) && (sw & SW_IT_MASK) == 32'h0) else $error("entry bits wrong");
    chk_entry_saved: assert property (tf || tn |=> o_saved_status_word == $past(sw))
        else $error("saved word wrong");
    chk_mask_block: assert property (run && !i_exc_req && !i_return_req && !i_status_wr && sw[SW_F_BIT] &&
        sw[SW_I_BIT] |=> o_ready && $stable(sw)) else $error("masked interrupt taken");
    chk_return_restore: assert property (run && !tk && i_return_req && i_return_flag_set && !i_status_wr &&
        sw[4:0] != MODE_USER && sw[4:0] != MODE_SYSTEM |=> sw == $past(o_saved_status_word)) else $error("no restore");
    chk_core_reset: assert property (!i_core_reset_low |=> o_in_reset && !o_ready && !o_fetch_redirect)
        else $error("core reset ignored");
    chk_reset_release: assert property (o_in_reset && i_core_reset_low && i_halt_hold_low |=>
        sw[4:0] == MODE_SUPER && sw[8:6] == 3'h7 && sw[SW_E_BIT] == $past(i_init_big_endian_cfg) &&
        sw[SW_T_BIT] == $past(i_init_compact_state_cfg) ##1 (s_vec and (o_fetch_vector == CLS_RESET)))
        else $error("reset release wrong");
endmodule

//--- pxee_testbench.sv
// Self-checking bench of the exception sequencer
`timescale 1ns/10ps
module testbench;
    import pxee_pkg::*;
    logic clk, rst, crl, hhl, cfg_e, cfg_t, cfg_nm, ebit, tbit, req, ret, rfs, swr, bwr, rd, rdy, inr;
    logic [2:0] cls, bwi, bri, vec;
    logic [31:0] addr, swd, bwd, sw, sv, lk, brd, es, ss;
    logic [31:0] bv [8];
    logic [1:0] fire, ack, irql;
    int err_count, samples_checked, cycles;
    pxee_irq_src src (.i_clk(clk), .i_rst(rst), .i_fire(fire), .i_ack(ack), .o_irq_low(irql));
    pxee_core dut (.i_clk(clk), .i_rst(rst), .i_core_reset_low(crl), .i_halt_hold_low(hhl),
        .i_init_big_endian_cfg(cfg_e), .i_init_compact_state_cfg(cfg_t), .i_unmaskable_fast_cfg(cfg_nm),
        .i_normal_irq_low(irql[0]), .i_fast_irq_low(irql[1]), .i_exception_endian_bit(ebit),
        .i_exception_state_bit(tbit), .i_exc_req(req), .i_exc_class(cls), .i_instr_addr(addr),
        .i_return_req(ret), .i_return_flag_set(rfs), .i_status_wr(swr), .i_status_wdata(swd),
        .i_bank_wr(bwr), .i_bank_widx(bwi), .i_bank_wdata(bwd), .i_bank_ridx(bri),
        .o_current_status_word(sw), .o_saved_status_word(sv), .o_return_link_reg(lk), .o_bank_rdata(brd),
        .o_fetch_redirect(rd), .o_fetch_vector(vec), .o_ready(rdy), .o_in_reset(inr));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d, mismatched %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic edges(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_rdy;
        repeat (20) begin
            edges(1);
            if (rdy === 1'b1) break;
        end
        check({rdy, rd}, 2'h3);
    endtask
    function automatic logic [31:0] ofs(input logic [2:0] c, input logic t);
        return c == CLS_DATA_ABORT ? LINK_OFS_DATA : (c <= CLS_UNDEF && t) ? LINK_OFS_COMPACT : LINK_OFS_WIDE;
    endfunction
    function automatic logic [31:0] entry(input logic [31:0] o, input logic [2:0] c);
        logic [31:0] n;
        n = o & ~SW_IT_MASK;
        n[4:0] = c == CLS_SVC ? MODE_SUPER : c == CLS_UNDEF ? MODE_UNDEF : MODE_ABORT;
        if (c == CLS_FAST_IRQ) n[4:0] = MODE_FAST;
        if (c == CLS_NORMAL_IRQ) n[4:0] = MODE_NORMAL;
        n[SW_E_BIT] = ebit;
        n[SW_T_BIT] = tbit;
        n[SW_I_BIT] = 1'b1;
        n[SW_F_BIT] = n[SW_F_BIT] | (c == CLS_FAST_IRQ);
        n[SW_A_BIT] = n[SW_A_BIT] | (c > CLS_UNDEF);
        return n;
    endfunction
    task automatic boot;
        @(posedge clk);
        crl <= 1'b1;
        hhl <= 1'b0;
        cfg_e <= 1'($urandom);
        cfg_t <= 1'($urandom);
        edges(2);
        check(inr, 1'b1);
        @(posedge clk);
        hhl <= 1'b1;
        wait_rdy;
        // Supervisor link left unchecked
        es = {22'h0, cfg_e, 3'h7, cfg_t, MODE_SUPER};
        check(sw, es);
        check(vec, CLS_RESET);
    endtask
    task automatic take(input logic [2:0] c);
        ss = es;
        @(posedge clk);
        req <= 1'b1;
        cls <= c;
        addr <= $urandom;
        ebit <= 1'($urandom);
        tbit <= 1'($urandom);
        @(posedge clk);
        req <= 1'b0;
        #1;
        es = entry(ss, c);
        check(sw, es);
        check(sv, ss);
        check(lk, addr + ofs(c, ss[SW_T_BIT]));
        wait_rdy;
        check(vec, c);
    endtask
    task automatic irq(input logic [1:0] m, input logic [2:0] c);
        ss = es;
        if (m != 2'h0) begin
            @(posedge clk);
            fire <= m;
            @(posedge clk);
            fire <= 2'h0;
        end
        edges(1);
        es = entry(ss, c);
        check(sw, es);
        check(sv, ss);
        check(lk, addr + LINK_OFS_WIDE);
        wait_rdy;
    endtask
    task automatic ret_op;
        @(posedge clk);
        ret <= 1'b1;
        rfs <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        #1;
        es = ss;
        check(sw, es);
    endtask
    task automatic swrite(input logic [31:0] d);
        @(posedge clk);
        swr <= 1'b1;
        swd <= d;
        @(posedge clk);
        swr <= 1'b0;
        #1;
        d[SW_F_BIT] = d[SW_F_BIT] & (es[SW_F_BIT] | !cfg_nm);
        es = (es & ~(SW_USER_WR_MASK | SW_PRIV_WR_MASK)) | (d & (SW_USER_WR_MASK | SW_PRIV_WR_MASK));
        // Privileged write of an unknown mode lands in system mode
        if (!(es[4:0] inside {MODE_USER, MODE_FAST, MODE_NORMAL, MODE_SUPER, MODE_ABORT, MODE_UNDEF, MODE_SYSTEM})) begin
            es[4:0] = MODE_SYSTEM;
        end
        check(sw, es);
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            wrap_up;
        end
    end
    initial begin
        {rst, crl, hhl, cfg_e, cfg_t, cfg_nm, ebit, tbit, req, ret, rfs, swr, bwr} = 13'h1000;
        {cls, bwi, bri, fire, ack} = 13'h0;
        {addr, swd, bwd} = 96'h0;
        void'($urandom(88627));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        boot;
        for (int i = 0; i < 30; i++) begin
            take(3'($urandom_range(4)));
            if ($urandom_range(1) == 0) begin
                ret_op;
            end
        end
        swrite(32'h00000013);
        irq(2'h3, CLS_FAST_IRQ);
        foreach (bv[k]) begin
            @(posedge clk);
            bv[k] = $urandom;
            bwr <= 1'b1;
            bwi <= 3'(k);
            bwd <= bv[k];
        end
        foreach (bv[k]) begin
            @(posedge clk);
            bwr <= 1'b0;
            bri <= 3'(k);
            edges(1);
            check(brd, bv[k]);
        end
        check(sw, es);
        @(posedge clk);
        ack <= 2'h2;
        @(posedge clk);
        ack <= 2'h0;
        ret_op;
        irq(2'h0, CLS_NORMAL_IRQ);
        swrite(es | 32'h00000040);
        @(posedge clk);
        ack <= 2'h1;
        fire <= 2'h2;
        @(posedge clk);
        ack <= 2'h0;
        fire <= 2'h0;
        edges(3);
        check(sw, es);
        ret_op;
        irq(2'h0, CLS_FAST_IRQ);
        @(posedge clk);
        ack <= 2'h2;
        cfg_nm <= 1'b1;
        @(posedge clk);
        ack <= 2'h0;
        ret_op;
        swrite(es | 32'h00000040);
        swrite((es & ~32'h0000001F) | 32'h00000015);
        @(posedge clk);
        crl <= 1'b0;
        edges(1);
        check(inr, 1'b1);
        check(rdy, 1'b0);
        boot;
        take(CLS_SVC);
        wrap_up;
    end
endmodule
bind pxee_core pxee_props chk (.i_clk, .i_rst, .i_core_reset_low, .i_halt_hold_low, .i_init_big_endian_cfg,
    .i_init_compact_state_cfg, .i_normal_irq_low, .i_fast_irq_low, .i_exception_endian_bit, .i_exception_state_bit,
    .i_exc_req, .i_exc_class, .i_instr_addr, .i_return_req, .i_return_flag_set, .i_status_wr,
    .o_current_status_word, .o_saved_status_word, .o_return_link_reg, .o_fetch_redirect, .o_fetch_vector,
    .o_ready, .o_in_reset);
